// ---- design/psp_pkg.sv ----
package psp_pkg;
	// Parameter numbers on the request port
	localparam logic [15:0] PNU_SET_NUM = 16'h03e8;
	localparam logic [15:0] PNU_DATA = 16'h03e9;
	localparam logic [15:0] PNU_START_SEL = 16'h03ea;
	localparam logic [15:0] PNU_PROFILE = 16'h03eb;
	localparam logic [15:0] PNU_OVERRIDE = 16'h03ec;
	// Sub-indices of the position data record
	localparam logic [7:0] SUB_TARGET = 8'h00;
	localparam logic [7:0] SUB_VELOCITY = 8'h01;
	localparam logic [7:0] SUB_END_VEL = 8'h02;
	localparam logic [7:0] SUB_ACCEL = 8'h03;
	localparam logic [7:0] SUB_DECEL = 8'h04;
	localparam logic [7:0] SUB_BOTH_ACCEL = 8'h05;
	localparam logic [7:0] SUB_JERK = 8'h06;
	localparam logic [7:0] SUB_NONE = 8'h00;
	// Set numbering
	localparam int NUM_SETS = 268;
	localparam logic [8:0] SET_JOG_LAST = 9'h104;
	localparam logic [8:0] SET_FIELDBUS = 9'h10a;
	localparam logic [7:0] SEL_FIELDBUS = 8'hff;
	// Values after reset
	localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
	localparam logic [31:0] VELOCITY_RESET = 32'h0000_03e8;
	localparam logic [31:0] END_VEL_RESET = 32'h0000_0000;
	localparam logic [31:0] ACCEL_RESET = 32'h0000_2710;
	localparam logic [31:0] JERK_RESET = 32'h0000_0000;
	localparam logic [8:0] SET_NUM_RESET = 9'h10a;
	localparam logic [7:0] START_SEL_RESET = 8'hff;
	localparam logic [15:0] PROFILE_RESET = 16'h0000;
	localparam logic [15:0] OVERRIDE_RESET = 16'h03e8;
	// Ranges and codes
	localparam logic [15:0] PROFILE_ZERO = 16'h0000;
	localparam logic [15:0] PROFILE_AUTO = 16'h0001;
	localparam logic [15:0] OVERRIDE_MAX = 16'h07d0;
	localparam logic [5:0] DIV_STEPS = 6'h20;
	// One stored position data set
	typedef struct packed {
		logic [31:0] target;
		logic [31:0] velocity;
		logic [31:0] end_vel;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] jerk;
	} psp_set_s;
endpackage : psp_pkg

// ---- design/psp_div_if.sv ----
`timescale 1ns/10ps
// Jerk time division request and result
interface psp_div_if;
	logic start;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic busy;
	logic done;
	logic [31:0] quotient;
	modport client (output start, output dividend, output divisor, input busy, input done, input quotient);
	modport server (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface : psp_div_if

// ---- design/psp_jerk_div.sv ----
`timescale 1ns/10ps
// Restoring divider, one quotient bit per cycle; a new start restarts it
module psp_jerk_div (
	input wire logic mclk,
	input wire logic srst,
	psp_div_if.server dv
);
	typedef enum logic {DIV_IDLE, DIV_RUN} psp_div_e;
	psp_div_e state;
	logic [32:0] rem;
	logic [31:0] quo;
	logic [31:0] den;
	logic [5:0] cnt;
	logic [32:0] next_rem_sh;

	// Shifted partial remainder
	assign next_rem_sh = {rem[31:0], quo[31]};
	assign dv.busy = (state == DIV_RUN);
	assign dv.quotient = quo;

	// Division sequence
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= DIV_IDLE;
			rem <= 33'h0_0000_0000;
			quo <= 32'h0000_0000;
			den <= 32'h0000_0000;
			cnt <= 6'h00;
			dv.done <= 1'b0;
		end else begin
			dv.done <= 1'b0;
			if (dv.start) begin
				// Any call, even mid-run, starts over from its own operands
				rem <= 33'h0_0000_0000;
				den <= dv.divisor;
				cnt <= psp_pkg::DIV_STEPS;
				if (dv.divisor == 32'h0000_0000) begin
					quo <= 32'h0000_0000; // No acceleration, no jerk filter
					dv.done <= 1'b1;
					state <= DIV_IDLE;
				end else begin
					quo <= dv.dividend;
					state <= DIV_RUN;
				end
			end else begin
				case (state)
					DIV_IDLE: state <= DIV_IDLE;
					DIV_RUN: begin
						if (next_rem_sh >= {1'b0, den}) begin
							rem <= next_rem_sh - {1'b0, den};
							quo <= {quo[30:0], 1'b1};
						end else begin
							rem <= next_rem_sh;
							quo <= {quo[30:0], 1'b0};
						end
						cnt <= cnt - 6'h01;
						if (cnt == 6'h01) begin
							state <= DIV_IDLE;
							dv.done <= 1'b1;
						end
					end
					default: state <= DIV_IDLE;
				endcase
			end
		end
	end
endmodule : psp_jerk_div

// ---- design/psp_param_store.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Selected set exposed as record: target, velocity, end velocity, accel, decel, combined.
// - Values are stored and returned in the configured fieldbus units, untouched.
// - Writing the combined sub-entry stores the value into acceleration and deceleration.
// - Reading the combined sub-entry returns the acceleration only.
// - A start command launches the set named by the start selector.
// - Selector 0 to 254 are stored sets, 255 means fieldbus set; default 255.
// - Profile type 0 zeroes set jerks once, at reset or on writing the type.
// - Profile type 1 recomputes jerk from velocity and acceleration at each call.
// - A call is the instant the start command arrives, not the motion start.
// - Override in per mille scales running move speed at once when changed.
// - Override returns to 1000 on every reset and is never saved.
// - Override never alters acceleration values, so braking is unaffected.
// - Set number chooses the addressed set: 0-255, homing, jogging, 266 fieldbus.
module psp_param_store (
	input wire logic mclk,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [15:0] req_pnu,
	input wire logic [7:0] req_sub,
	input wire logic [31:0] req_wdata,
	input wire logic start_cmd,
	output logic rsp_valid,
	output logic rsp_error,
	output logic [31:0] rsp_rdata,
	output logic call_pulse,
	output logic [8:0] call_set,
	output logic [31:0] call_target,
	output logic [31:0] call_velocity,
	output logic [31:0] call_end_vel,
	output logic [31:0] call_accel,
	output logic [31:0] call_decel,
	output logic [31:0] call_jerk,
	output logic jerk_update,
	output logic [15:0] override_factor
);
	psp_pkg::psp_set_s sets [psp_pkg::NUM_SETS];
	logic [8:0] set_num;
	logic [7:0] start_sel;
	logic [15:0] profile_type;
	logic [8:0] jerk_idx;
	logic [8:0] next_call_idx;
	logic acc_ok;
	logic [31:0] next_rdata;
	logic wr_rec;
	logic wr_profile;
	psp_pkg::psp_set_s cur;
	psp_pkg::psp_set_s called;

	psp_div_if div_bus ();

	psp_jerk_div u_jerk_div (
		.mclk(mclk),
		.srst(srst),
		.dv(div_bus.server)
	);

	// Addressed and called sets
	assign cur = sets[set_num];
	assign next_call_idx = (start_sel == psp_pkg::SEL_FIELDBUS) ? psp_pkg::SET_FIELDBUS : {1'b0, start_sel};
	assign called = sets[next_call_idx];

	// Request decode, range check and read data
	always_comb begin
		acc_ok = 1'b0;
		next_rdata = 32'h0000_0000;
		case (req_pnu)
			psp_pkg::PNU_SET_NUM: begin
				acc_ok = (req_sub == psp_pkg::SUB_NONE) && (!req_write ||
					(req_wdata <= {23'h000000, psp_pkg::SET_JOG_LAST}) ||
					(req_wdata == {23'h000000, psp_pkg::SET_FIELDBUS}));
				next_rdata = {23'h000000, set_num};
			end
			psp_pkg::PNU_DATA: begin
				acc_ok = (req_sub <= psp_pkg::SUB_JERK);
				case (req_sub)
					psp_pkg::SUB_TARGET: next_rdata = cur.target;
					psp_pkg::SUB_VELOCITY: next_rdata = cur.velocity;
					psp_pkg::SUB_END_VEL: next_rdata = cur.end_vel;
					psp_pkg::SUB_ACCEL: next_rdata = cur.accel;
					psp_pkg::SUB_DECEL: next_rdata = cur.decel;
					psp_pkg::SUB_BOTH_ACCEL: next_rdata = cur.accel;
					psp_pkg::SUB_JERK: next_rdata = cur.jerk;
					default: next_rdata = 32'h0000_0000;
				endcase
			end
			psp_pkg::PNU_START_SEL: begin
				acc_ok = (req_sub == psp_pkg::SUB_NONE) && (!req_write || (req_wdata[31:8] == 24'h000000));
				next_rdata = {24'h000000, start_sel};
			end
			psp_pkg::PNU_PROFILE: begin
				acc_ok = (req_sub == psp_pkg::SUB_NONE) &&
					(!req_write || (req_wdata <= {16'h0000, psp_pkg::PROFILE_AUTO}));
				next_rdata = {16'h0000, profile_type};
			end
			psp_pkg::PNU_OVERRIDE: begin
				acc_ok = (req_sub == psp_pkg::SUB_NONE) &&
					(!req_write || (req_wdata <= {16'h0000, psp_pkg::OVERRIDE_MAX}));
				next_rdata = {16'h0000, override_factor};
			end
			default: begin
				acc_ok = 1'b0;
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	assign wr_rec = req_valid && req_write && acc_ok && (req_pnu == psp_pkg::PNU_DATA);
	assign wr_profile = req_valid && req_write && acc_ok && (req_pnu == psp_pkg::PNU_PROFILE);

	// Answer one cycle after each request
	always_ff @(posedge mclk) begin
		if (srst) begin
			rsp_valid <= 1'b0;
			rsp_error <= 1'b0;
			rsp_rdata <= 32'h0000_0000;
		end else begin
			rsp_valid <= req_valid;
			rsp_error <= req_valid && !acc_ok;
			rsp_rdata <= (req_valid && acc_ok && !req_write) ? next_rdata : 32'h0000_0000;
		end
	end

	// Answer timing and refusals
	a_resp_one_cycle: assert property (@(posedge mclk) disable iff (srst) req_valid |=> rsp_valid)
		else $error("Request not answered next cycle");
	a_write_no_data: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write
		|=> rsp_rdata == 32'h0000_0000)
		else $error("Write answer carried data");
	a_unknown_pnu: assert property (@(posedge mclk) disable iff (srst)
		req_valid && (req_pnu < psp_pkg::PNU_SET_NUM || req_pnu > psp_pkg::PNU_OVERRIDE)
		|=> rsp_error && rsp_rdata == 32'h0000_0000)
		else $error("Unknown parameter not refused");
	a_bad_sub: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_pnu == psp_pkg::PNU_DATA && req_sub > psp_pkg::SUB_JERK
		|=> rsp_error)
		else $error("Record sub-index out of range accepted");
	a_both_read: assert property (@(posedge mclk) disable iff (srst)
		req_valid && !req_write && req_pnu == psp_pkg::PNU_DATA && req_sub == psp_pkg::SUB_BOTH_ACCEL
		|=> rsp_rdata == $past(cur.accel))
		else $error("Combined read not acceleration");

	// Scalar parameters
	always_ff @(posedge mclk) begin
		if (srst) begin
			set_num <= psp_pkg::SET_NUM_RESET;
			start_sel <= psp_pkg::START_SEL_RESET;
			profile_type <= psp_pkg::PROFILE_RESET;
			override_factor <= psp_pkg::OVERRIDE_RESET;
		end else if (req_valid && req_write && acc_ok) begin
			case (req_pnu)
				psp_pkg::PNU_SET_NUM: set_num <= req_wdata[8:0];
				psp_pkg::PNU_START_SEL: start_sel <= req_wdata[7:0];
				psp_pkg::PNU_PROFILE: profile_type <= req_wdata[15:0];
				psp_pkg::PNU_OVERRIDE: override_factor <= req_wdata[15:0];
				default: set_num <= set_num;
			endcase
		end
	end

	// Scalar parameter writes and refusals
	a_override_range: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_OVERRIDE && req_wdata > 32'h0000_07d0
		|=> rsp_error && $stable(override_factor))
		else $error("Override out of range accepted");
	a_override_apply: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_OVERRIDE && req_sub == 8'h00 && req_wdata <= 32'h0000_07d0
		|=> override_factor == $past(req_wdata[15:0]))
		else $error("Override not applied at once");
	a_override_reset: assert property (@(posedge mclk) $past(srst) |-> override_factor == 16'h03e8)
		else $error("Override not full speed after reset");
	a_set_num_refuse: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_SET_NUM &&
		req_wdata > 32'h0000_0104 && req_wdata != 32'h0000_010a
		|=> rsp_error && $stable(set_num))
		else $error("Reserved set number accepted");
	a_start_sel_refuse: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_START_SEL && req_wdata > 32'h0000_00ff
		|=> rsp_error && $stable(start_sel))
		else $error("Selector above 255 accepted");
	a_start_sel_apply: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_START_SEL && req_sub == 8'h00 && req_wdata <= 32'h0000_00ff
		|=> start_sel == $past(req_wdata[7:0]))
		else $error("Selector write not applied");
	a_profile_refuse: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_PROFILE && req_wdata > 32'h0000_0001
		|=> rsp_error && $stable(profile_type))
		else $error("Profile type above 1 accepted");

	// Set storage, values kept in the caller's units as written
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < psp_pkg::NUM_SETS; i++) begin
				sets[i].target <= psp_pkg::TARGET_RESET;
				sets[i].velocity <= psp_pkg::VELOCITY_RESET;
				sets[i].end_vel <= psp_pkg::END_VEL_RESET;
				sets[i].accel <= psp_pkg::ACCEL_RESET;
				sets[i].decel <= psp_pkg::ACCEL_RESET;
				sets[i].jerk <= psp_pkg::JERK_RESET;
			end
		end else begin
			if (div_bus.done) begin
				sets[jerk_idx].jerk <= div_bus.quotient;
			end
			if (wr_rec) begin
				case (req_sub)
					psp_pkg::SUB_TARGET: sets[set_num].target <= req_wdata;
					psp_pkg::SUB_VELOCITY: sets[set_num].velocity <= req_wdata;
					psp_pkg::SUB_END_VEL: sets[set_num].end_vel <= req_wdata;
					psp_pkg::SUB_ACCEL: sets[set_num].accel <= req_wdata;
					psp_pkg::SUB_DECEL: sets[set_num].decel <= req_wdata;
					psp_pkg::SUB_BOTH_ACCEL: begin
						sets[set_num].accel <= req_wdata;
						sets[set_num].decel <= req_wdata;
					end
					psp_pkg::SUB_JERK: sets[set_num].jerk <= req_wdata;
					default: sets[set_num].jerk <= sets[set_num].jerk;
				endcase
			end
			if (wr_profile && (req_wdata[15:0] == psp_pkg::PROFILE_ZERO)) begin
				for (int i = 0; i < psp_pkg::NUM_SETS; i++) begin
					sets[i].jerk <= psp_pkg::JERK_RESET;
				end
			end
		end
	end

	// Record writes and jerk zeroing
	a_data_write: assert property (@(posedge mclk) disable iff (srst)
		wr_rec && req_sub == psp_pkg::SUB_TARGET
		|=> cur.target == $past(req_wdata))
		else $error("Target not stored as written");
	a_both_accel: assert property (@(posedge mclk) disable iff (srst)
		wr_rec && req_sub == psp_pkg::SUB_BOTH_ACCEL
		|=> cur.accel == $past(req_wdata) && cur.decel == $past(req_wdata))
		else $error("Combined write missed a field");
	a_jerk_zeroed: assert property (@(posedge mclk) disable iff (srst)
		wr_profile && req_wdata == 32'h0000_0000 && !start_cmd
		|=> cur.jerk == 32'h0000_0000)
		else $error("Jerk not zeroed by profile write");
	a_profile_one_keeps: assert property (@(posedge mclk) disable iff (srst)
		wr_profile && req_wdata == 32'h0000_0001 && !div_bus.done
		|=> $stable(cur.jerk))
		else $error("Profile 1 write altered a jerk");

	// Set call at the instant the start command arrives
	always_ff @(posedge mclk) begin
		if (srst) begin
			call_pulse <= 1'b0;
			call_set <= psp_pkg::SET_FIELDBUS;
			call_target <= psp_pkg::TARGET_RESET;
			call_velocity <= psp_pkg::VELOCITY_RESET;
			call_end_vel <= psp_pkg::END_VEL_RESET;
			call_accel <= psp_pkg::ACCEL_RESET;
			call_decel <= psp_pkg::ACCEL_RESET;
		end else begin
			call_pulse <= start_cmd;
			if (start_cmd) begin
				call_set <= next_call_idx;
				call_target <= called.target;
				call_velocity <= called.velocity;
				call_end_vel <= called.end_vel;
				call_accel <= called.accel;
				call_decel <= called.decel;
			end
		end
	end

	// Set call snapshot
	a_call_fieldbus: assert property (@(posedge mclk) disable iff (srst)
		start_cmd && start_sel == 8'hff
		|=> call_pulse && call_set == 9'h10a)
		else $error("Selector 255 not mapped to fieldbus set");
	a_call_stored: assert property (@(posedge mclk) disable iff (srst)
		start_cmd && start_sel != 8'hff
		|=> call_set == {1'b0, $past(start_sel)})
		else $error("Stored set not called as selected");
	a_call_instant: assert property (@(posedge mclk) disable iff (srst)
		start_cmd
		|=> call_pulse && call_set == $past(next_call_idx))
		else $error("Call not taken at start command");
	a_call_snapshot: assert property (@(posedge mclk) disable iff (srst)
		start_cmd
		|=> call_target == $past(called.target) && call_velocity == $past(called.velocity) &&
		call_end_vel == $past(called.end_vel) && call_decel == $past(called.decel))
		else $error("Called set fields not captured");
	a_call_pulse_once: assert property (@(posedge mclk) disable iff (srst)
		!start_cmd
		|=> !call_pulse)
		else $error("Call pulse without start command");
	a_accel_kept: assert property (@(posedge mclk) disable iff (srst)
		req_valid && req_write && req_pnu == psp_pkg::PNU_OVERRIDE && !start_cmd
		|=> $stable(call_accel))
		else $error("Override changed acceleration");

	// Jerk recomputation launched by each call in automatic mode
	always_ff @(posedge mclk) begin
		if (srst) begin
			div_bus.start <= 1'b0;
			div_bus.dividend <= 32'h0000_0000;
			div_bus.divisor <= 32'h0000_0000;
			jerk_idx <= psp_pkg::SET_FIELDBUS;
		end else begin
			div_bus.start <= start_cmd && (profile_type == psp_pkg::PROFILE_AUTO);
			if (start_cmd && (profile_type == psp_pkg::PROFILE_AUTO)) begin // Plain calls keep the writeback target
				div_bus.dividend <= called.velocity;
				div_bus.divisor <= called.accel;
				jerk_idx <= next_call_idx;
			end
		end
	end

	// Jerk of the called set, current or freshly computed
	always_ff @(posedge mclk) begin
		if (srst) begin
			call_jerk <= psp_pkg::JERK_RESET;
			jerk_update <= 1'b0;
		end else begin
			jerk_update <= div_bus.done;
			if (div_bus.done) begin
				call_jerk <= div_bus.quotient;
			end else if (start_cmd) begin
				call_jerk <= called.jerk;
			end
		end
	end

	// Jerk recomputation, a newer call may restart it
	a_jerk_launch: assert property (@(posedge mclk) disable iff (srst)
		start_cmd && profile_type == 16'h0001
		|=> div_bus.start ##[1:34] (div_bus.done || div_bus.start))
		else $error("Jerk recomputation not finished");
	a_no_auto_div: assert property (@(posedge mclk) disable iff (srst)
		start_cmd && profile_type == psp_pkg::PROFILE_ZERO
		|=> !div_bus.start)
		else $error("Division started in profile 0");
	a_div_restart: assert property (@(posedge mclk) disable iff (srst)
		div_bus.busy && div_bus.start
		|=> div_bus.busy || div_bus.done)
		else $error("Newer call did not restart division");
	a_jerk_write_back: assert property (@(posedge mclk) disable iff (srst)
		div_bus.done
		|=> jerk_update && call_jerk == $past(div_bus.quotient))
		else $error("Computed jerk not handed over");
endmodule : psp_param_store

// ---- testbench/psp_fieldbus_model.sv ----
`timescale 1ns/10ps
// Fieldbus controller: one parameter request at a time
module psp_fieldbus_model (
	input wire logic mclk,
	output logic req_valid,
	output logic req_write,
	output logic [15:0] req_pnu,
	output logic [7:0] req_sub,
	output logic [31:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire logic [31:0] rsp_rdata
);
	// Idle request lines
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_pnu = 16'h0000;
		req_sub = 8'h00;
		req_wdata = 32'h0000_0000;
	end

	// Drive on falling edge, scramble qualifiers one cycle later, then take answer
	task automatic access(input logic wr, input logic [15:0] pnu, input logic [7:0] sub, input logic [31:0] wd,
		output logic err, output logic [31:0] rd);
		@(negedge mclk);
		req_valid = 1'b1;
		req_write = wr;
		req_pnu = pnu;
		req_sub = sub;
		req_wdata = wd;
		@(negedge mclk);
		req_valid = 1'b0;
		req_write = ~wr;
		req_pnu = ~pnu;
		req_sub = ~sub;
		req_wdata = ~wd;
		err = rsp_valid ? rsp_error : 1'bx; // Missing answer never matches
		rd = rsp_rdata;
	endtask : access
endmodule : psp_fieldbus_model

// ---- testbench/positioning_set_parameters_tb.sv ----
`timescale 1ns/10ps
module positioning_set_parameters_tb;
	logic mclk;
	logic srst;
	logic start_cmd;
	logic req_valid, req_write, rsp_valid, rsp_error, call_pulse, jerk_update;
	logic [15:0] req_pnu, override_factor;
	logic [7:0] req_sub;
	logic [31:0] req_wdata, rsp_rdata, call_target, call_velocity, call_end_vel, call_accel, call_decel, call_jerk;
	logic [8:0] call_set;
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] v, a, t, rec_rst [6];
	logic [7:0] sel;
	logic [8:0] sn;
	logic done;

	// Clock, 25 ns period
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	psp_fieldbus_model fb (.mclk(mclk), .req_valid(req_valid), .req_write(req_write), .req_pnu(req_pnu),
		.req_sub(req_sub), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));

	psp_param_store dut (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_write(req_write), .req_pnu(req_pnu),
		.req_sub(req_sub), .req_wdata(req_wdata), .start_cmd(start_cmd), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
		.rsp_rdata(rsp_rdata), .call_pulse(call_pulse), .call_set(call_set), .call_target(call_target),
		.call_velocity(call_velocity), .call_end_vel(call_end_vel), .call_accel(call_accel), .call_decel(call_decel),
		.call_jerk(call_jerk), .jerk_update(jerk_update), .override_factor(override_factor));

	// Expected called set index for a selector value
	function automatic logic [8:0] called_index(input logic [7:0] s);
		return (s == psp_pkg::SEL_FIELDBUS) ? psp_pkg::SET_FIELDBUS : {1'b0, s};
	endfunction : called_index

	// Expected jerk quotient
	function automatic logic [31:0] jerk_of(input logic [31:0] vel, input logic [31:0] acc);
		return (acc == 32'h0) ? 32'h0 : vel / acc;
	endfunction : jerk_of

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [15:0] pnu, input logic [7:0] sub, input logic [31:0] d, input logic exp_err);
		logic e;
		logic [31:0] r;
		fb.access(1'b1, pnu, sub, d, e, r);
		check({31'h0, e}, {31'h0, exp_err});
		check(r, 32'h0);
	endtask : wr

	task automatic rd(input logic [15:0] pnu, input logic [7:0] sub, input logic [31:0] exp);
		logic e;
		logic [31:0] r;
		fb.access(1'b0, pnu, sub, 32'h0, e, r);
		check({31'h0, e}, 32'h0);
		check(r, exp);
	endtask : rd

	task automatic do_reset();
		srst = 1'b1;
		repeat (6) @(negedge mclk);
		srst = 1'b0;
	endtask : do_reset

	// One start pulse, call outputs looked at the cycle after
	task automatic start_set(input logic [8:0] exp_set);
		@(negedge mclk);
		start_cmd = 1'b1;
		@(negedge mclk);
		start_cmd = 1'b0;
		check({31'h0, call_pulse}, 32'h1);
		check({23'h0, call_set}, {23'h0, exp_set});
	endtask : start_set

	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Hang guard
	initial begin
		#(25 * 20000);
		n_errors++;
		complete_run();
	end

	initial begin
		srst = 1'b1;
		start_cmd = 1'b0;
		void'($urandom(59));
		rec_rst = '{psp_pkg::TARGET_RESET, psp_pkg::VELOCITY_RESET, psp_pkg::END_VEL_RESET, psp_pkg::ACCEL_RESET,
			psp_pkg::ACCEL_RESET, psp_pkg::ACCEL_RESET};
		do_reset();
		// Values after reset
		for (int i = 0; i < 6; i++) rd(psp_pkg::PNU_DATA, 8'(i), rec_rst[i]);
		rd(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_010a);
		rd(psp_pkg::PNU_START_SEL, 8'h00, 32'h0000_00ff);
		rd(psp_pkg::PNU_PROFILE, 8'h00, 32'h0);
		rd(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_03e8);
		// Random set, fields written and read back unscaled
		for (int k = 0; k < 4; k++) begin
			sn = 9'($urandom_range(0, 260));
			wr(psp_pkg::PNU_SET_NUM, 8'h00, {23'h0, sn}, 1'b0);
			for (int i = 0; i < 5; i++) begin
				v = $urandom;
				wr(psp_pkg::PNU_DATA, 8'(i), v, 1'b0);
				rd(psp_pkg::PNU_DATA, 8'(i), v);
			end
			v = $urandom;
			a = $urandom;
			wr(psp_pkg::PNU_DATA, psp_pkg::SUB_BOTH_ACCEL, v, 1'b0);
			rd(psp_pkg::PNU_DATA, psp_pkg::SUB_DECEL, v);
			wr(psp_pkg::PNU_DATA, psp_pkg::SUB_DECEL, a, 1'b0);
			rd(psp_pkg::PNU_DATA, psp_pkg::SUB_BOTH_ACCEL, v);
		end
		// Jog set does not leak into fieldbus set
		wr(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_0103, 1'b0);
		wr(psp_pkg::PNU_DATA, psp_pkg::SUB_VELOCITY, 32'h0000_0777, 1'b0);
		wr(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_0107, 1'b1);
		wr(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_010b, 1'b1);
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_VELOCITY, 32'h0000_0777);
		wr(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_010a, 1'b0);
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_VELOCITY, 32'h0000_03e8);
		// Refused values and codes
		wr(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_07d1, 1'b1);
		wr(psp_pkg::PNU_PROFILE, 8'h00, 32'h0000_0002, 1'b1);
		wr(psp_pkg::PNU_START_SEL, 8'h00, 32'h0000_0100, 1'b1);
		wr(psp_pkg::PNU_DATA, 8'h07, 32'h0, 1'b1);
		wr(16'h03ed, 8'h00, 32'h0, 1'b1);
		rd(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_03e8);
		// Start of a stored set
		sel = 8'($urandom_range(0, 254));
		t = $urandom;
		wr(psp_pkg::PNU_SET_NUM, 8'h00, {24'h0, sel}, 1'b0);
		wr(psp_pkg::PNU_DATA, psp_pkg::SUB_TARGET, t, 1'b0);
		wr(psp_pkg::PNU_START_SEL, 8'h00, {24'h0, sel}, 1'b0);
		start_set(called_index(sel));
		check(call_target, t);
		// Automatic jerk on the fieldbus set
		v = $urandom_range(1, 100000);
		a = $urandom_range(1, 1000);
		wr(psp_pkg::PNU_SET_NUM, 8'h00, 32'h0000_010a, 1'b0);
		wr(psp_pkg::PNU_DATA, psp_pkg::SUB_VELOCITY, v, 1'b0);
		wr(psp_pkg::PNU_DATA, psp_pkg::SUB_ACCEL, a, 1'b0);
		wr(psp_pkg::PNU_PROFILE, 8'h00, 32'h0000_0001, 1'b0);
		wr(psp_pkg::PNU_START_SEL, 8'h00, 32'h0000_00ff, 1'b0);
		start_set(called_index(8'hff));
		check(call_accel, a);
		check(call_velocity, v);
		check(call_decel, psp_pkg::ACCEL_RESET);
		check(call_end_vel, psp_pkg::END_VEL_RESET);
		check(call_target, psp_pkg::TARGET_RESET);
		start_set(called_index(8'hff));
		done = 1'b0;
		for (int i = 0; i < 40 && !done; i++) begin
			@(negedge mclk);
			done = (jerk_update === 1'b1);
		end
		check({31'h0, done}, 32'h1);
		check(call_jerk, jerk_of(v, a));
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_JERK, jerk_of(v, a));
		// Profile 0 zeroes jerk once; later edits stay
		wr(psp_pkg::PNU_PROFILE, 8'h00, 32'h0, 1'b0);
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_JERK, 32'h0);
		wr(psp_pkg::PNU_DATA, psp_pkg::SUB_JERK, 32'h0000_0007, 1'b0);
		start_set(called_index(8'hff));
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_JERK, 32'h0000_0007);
		// Override takes effect at once, accel untouched
		wr(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_07d0, 1'b0);
		wr(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_01f4, 1'b0);
		check({16'h0, override_factor}, 32'h0000_01f4);
		rd(psp_pkg::PNU_DATA, psp_pkg::SUB_ACCEL, a);
		// Second reset brings override back
		do_reset();
		check({16'h0, override_factor}, 32'h0000_03e8);
		rd(psp_pkg::PNU_OVERRIDE, 8'h00, 32'h0000_03e8);
		complete_run();
	end
endmodule : positioning_set_parameters_tb
